// ===== common/bdec_pkg.sv
/*
 * constants for the bridge discard-error control block.
 * assumes a configuration access port of 16-bit register granularity.
 */
// Functional notes
// - bits 15:12 of bridge control read zero, writes to them ignored
// - bridge control at offset 3eh, 16 bits, reset to zero
// - report enable acts only in conventional parallel-bus mode
// - enable set and discard happens: send nonfatal or fatal message upstream
// - nonfatal by default; fatal only selectable with advanced error reporting
// - enable clear: message still sent via advanced reporting if mask clear
// - expired flag sets on discard, sticky until software clears it
// - count starts at queue head; 2^15 clocks if select 0, 2^10 if 1
package bdec_pkg;
    localparam logic [7:0]  BRIDGE_CONTROL_OFFSET = 8'h3e;
    localparam logic [15:0] BRIDGE_CONTROL_RESET  = 16'h0000;
    localparam int          REPORT_ENABLE_BIT     = 11;
    localparam int          EXPIRED_FLAG_BIT      = 10;
    localparam int          PERIOD_SELECT_BIT     = 9;
    localparam int          LONG_PERIOD_LOG2      = 15;
    localparam int          SHORT_PERIOD_LOG2     = 10;
    localparam int          COUNT_WIDTH           = 16;
    localparam logic [15:0] WRITABLE_MASK         = 16'h0a00;
    localparam logic [15:0] RESERVED_MASK         = 16'hf000;
endpackage

// ===== hdl/bdec_discard_timer.sv
/*
 * secondary discard timer: counts from queue head until repeat or expiry.
 * assumes start and repeat are synchronous pulses/levels on clk.
 */
`timescale 1ns/100ps
module bdec_discard_timer #(
    parameter int COUNT_WIDTH = bdec_pkg::COUNT_WIDTH,
    parameter int LONG_LOG2   = bdec_pkg::LONG_PERIOD_LOG2,
    parameter int SHORT_LOG2  = bdec_pkg::SHORT_PERIOD_LOG2
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic period_select,
    input  wire logic head_reached,
    input  wire logic repeat_seen,
    output logic      expired
);
    logic                   run_reg;
    logic                   run_next;
    logic [COUNT_WIDTH-1:0] cnt_reg;
    logic [COUNT_WIDTH-1:0] cnt_next;
    logic [COUNT_WIDTH-1:0] limit;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_comb
    begin
        limit    = period_select ? COUNT_WIDTH'((1 << SHORT_LOG2) - 1)
                                 : COUNT_WIDTH'((1 << LONG_LOG2) - 1);
        expired  = run_reg && (cnt_reg == limit) && !repeat_seen;
        run_next = run_reg;
        cnt_next = cnt_reg;
        if (repeat_seen || expired)
        begin
            run_next = 1'b0;
            cnt_next = '0;
        end
        else if (run_reg)
        begin
            cnt_next = cnt_reg + COUNT_WIDTH'(1);
        end
        else if (head_reached)
        begin
            run_next = 1'b1;
            cnt_next = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else
        begin
            run_reg <= run_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule // bdec_discard_timer

// ===== hdl/bdec_bridge_control.sv
/*
 * bridge control register discard-error fields plus upstream error request.
 * assumes configuration accesses and events are synchronous to clk.
 */
`timescale 1ns/100ps
module bdec_bridge_control #(
    parameter bit AER_SUPPORTED = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [15:0] cfg_wdata,
    input  wire logic [1:0]  cfg_be,
    output logic      [15:0] cfg_rdata,
    input  wire logic        conventional_mode,
    input  wire logic        aer_fatal_severity,
    input  wire logic        aer_discard_mask,
    input  wire logic        completion_at_head,
    input  wire logic        master_repeated,
    output logic             discard_pulse,
    output logic             err_msg_valid,
    output logic             err_msg_fatal
);

    // ------------------------------------------------------------
    // local signals
    // ------------------------------------------------------------
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic        flag_reg;
    logic        flag_next;
    logic [15:0] reg_view;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        msg_v_reg;
    logic        msg_v_next;
    logic        msg_f_reg;
    logic        msg_f_next;
    logic        expired;
    logic        hit;
    logic        wr_hit;
    logic        rd_hit;
    logic [15:0] wmask;
    logic [15:0] wr_bits;
    logic        flag_clear;
    logic        report;
    logic        discard_error_report_enable;
    logic        secondary_discard_period_select;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    assign discard_error_report_enable     = ctrl_reg[bdec_pkg::REPORT_ENABLE_BIT];
    assign secondary_discard_period_select = ctrl_reg[bdec_pkg::PERIOD_SELECT_BIT];

    // ------------------------------------------------------------
    // discard timer
    // ------------------------------------------------------------
    bdec_discard_timer u_timer (
        .clk           (clk),
        .rst_n         (rst_n),
        .period_select (secondary_discard_period_select),
        .head_reached  (completion_at_head),
        .repeat_seen   (master_repeated),
        .expired       (expired)
    );

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb
    begin
        hit        = (cfg_addr == bdec_pkg::BRIDGE_CONTROL_OFFSET);
        wr_hit     = cfg_wr && hit;
        rd_hit     = cfg_rd && hit;
        wmask      = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
        wr_bits    = wmask & bdec_pkg::WRITABLE_MASK;
        flag_clear = wr_hit && cfg_be[1] && cfg_wdata[bdec_pkg::EXPIRED_FLAG_BIT];
    end

    // ------------------------------------------------------------
    // writable control bits
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr_hit)
        begin
            // only enable and select are writable; top nibble stays zero
            ctrl_next = (ctrl_reg & ~wr_bits) | (cfg_wdata & wr_bits);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= bdec_pkg::BRIDGE_CONTROL_RESET;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ------------------------------------------------------------
    // sticky expired flag
    // ------------------------------------------------------------
    always_comb
    begin
        flag_next = flag_reg;
        if (flag_clear)
        begin
            // write one to clear
            flag_next = 1'b0;
        end
        if (expired)
        begin
            // set wins over a clear in the same cycle
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_reg <= bdec_pkg::BRIDGE_CONTROL_RESET[bdec_pkg::EXPIRED_FLAG_BIT];
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    // ------------------------------------------------------------
    // register view and read data
    // ------------------------------------------------------------
    always_comb
    begin
        reg_view = ctrl_reg;
        reg_view[bdec_pkg::EXPIRED_FLAG_BIT] = flag_reg;
    end

    always_comb
    begin
        rdata_next = rdata_reg;
        if (cfg_rd)
        begin
            rdata_next = '0;
            if (rd_hit)
            begin
                rdata_next = reg_view & ~bdec_pkg::RESERVED_MASK;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= '0;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // upstream message request
    // ------------------------------------------------------------
    always_comb
    begin
        report     = (conventional_mode && discard_error_report_enable)
                   || (AER_SUPPORTED && !aer_discard_mask);
        msg_v_next = expired && report;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msg_v_reg <= 1'b0;
        end
        else
        begin
            msg_v_reg <= msg_v_next;
        end
    end

    // ------------------------------------------------------------
    // message severity
    // ------------------------------------------------------------
    always_comb
    begin
        // fatal only when the advanced reporting path exists
        msg_f_next = msg_v_next && AER_SUPPORTED && aer_fatal_severity;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msg_f_reg <= 1'b0;
        end
        else
        begin
            msg_f_reg <= msg_f_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cfg_rdata     = rdata_reg;
    assign discard_pulse = expired;
    assign err_msg_valid = msg_v_reg;
    assign err_msg_fatal = msg_f_reg;
endmodule // bdec_bridge_control

// ===== verification/bdec_props.sv
/* bridge control checker. bound to bdec_bridge_control ports, aer assumed built in. */
`timescale 1ns/100ps
module bdec_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cfg_rd,
    input wire logic        discard_pulse,
    input wire logic        master_repeated,
    input wire logic        err_msg_valid,
    input wire logic        err_msg_fatal,
    input wire logic        aer_fatal_severity,
    input wire logic        aer_discard_mask,
    input wire logic [7:0]  cfg_addr,
    input wire logic [15:0] cfg_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_rsvd_reads_zero: assert property (cfg_rdata[15:12] == 4'h0)
        else $error("reserved bits set");
    a_unmapped_reads_zero: assert property (
        $past(cfg_rd) && $past(cfg_addr) != 8'h3e |-> cfg_rdata == 16'h0)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!$past(cfg_rd) |-> $stable(cfg_rdata))
        else $error("read data moved");
    a_aer_msg_sent: assert property (discard_pulse && !aer_discard_mask |=> err_msg_valid)
        else $error("no message");
    a_msg_has_cause: assert property (err_msg_valid |-> $past(discard_pulse))
        else $error("message without discard");
    a_one_msg_only: assert property (err_msg_valid |=> !err_msg_valid)
        else $error("repeated message");
    a_nonfatal_default: assert property (
        err_msg_valid && !$past(aer_fatal_severity) |-> !err_msg_fatal)
        else $error("fatal without select");
    a_repeat_cancels: assert property (master_repeated |-> !discard_pulse)
        else $error("discard despite repeat");
endmodule // bdec_props

// ===== verification/bdec_upstream_model.sv
/* upstream message sink, counts error messages. assumes one-cycle message pulses. */
`timescale 1ns/100ps
module bdec_upstream_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       err_msg_valid,
    input  wire logic       err_msg_fatal,
    output logic      [7:0] msg_cnt
);
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) msg_cnt <= 8'h0;
        else if (err_msg_valid) msg_cnt <= msg_cnt + 8'h1;
endmodule // bdec_upstream_model

// ===== verification/tb_top.sv
/* bench for bdec_bridge_control. assumes aer built in, timer at design defaults. */
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, conv = 0, fat = 0, msk = 1, head = 0, rep = 0;
    logic rd_seen = 0, dp, mv, mf;
    logic [7:0] addr = 0, cnt;
    logic [1:0] be = 3;
    logic [15:0] wd = 0, rdata, w;
    logic [16:0] q[$], e, obs;
    int errors = 0, n_checks = 0, cyc = 0, seed = 88370;
    initial forever #20 clk = ~clk;
    bdec_bridge_control dut (.clk(clk), .rst_n(rst_n), .cfg_wr(wr), .cfg_rd(rd),
        .cfg_addr(addr), .cfg_wdata(wd), .cfg_be(be), .cfg_rdata(rdata),
        .conventional_mode(conv), .aer_fatal_severity(fat), .aer_discard_mask(msk),
        .completion_at_head(head), .master_repeated(rep), .discard_pulse(dp),
        .err_msg_valid(mv), .err_msg_fatal(mf));
    bdec_upstream_model up (.clk(clk), .rst_n(rst_n), .err_msg_valid(mv),
        .err_msg_fatal(mf), .msg_cnt(cnt));
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) if (rd_seen || mv) begin
        obs = mv ? {1'b1, 15'h0, mf} : {1'b0, rdata};
        e = q.size() ? q.pop_front() : ~obs;
        `CHK(obs, e)
    end
    always @(posedge clk) if (++cyc == 50000) begin errors++; final_report; end
    task final_report;
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task acc(input logic w_en, input logic [7:0] a, input logic [15:0] d, ex);
        @(negedge clk); wr = w_en; rd = !w_en; addr = a; wd = d;
        if (!w_en) q.push_back({1'b0, ex});
        @(negedge clk); wr = 0; rd = 0;
    endtask
    task run(input logic c, f, m, r, msg, s);
        int i;
        int x;
        conv = c; fat = f; msk = m;
        if (msg) q.push_back({1'b1, 15'h0, f});
        @(negedge clk); head = 1; @(negedge clk); head = 0;
        repeat (r ? 100 : 0) @(negedge clk); rep = r; @(negedge clk); rep = 0;
        for (i = 0; i < (s ? 1100 : 33000) && !dp; i++) @(negedge clk);
        x = (1 << (s ? bdec_pkg::SHORT_PERIOD_LOG2 : bdec_pkg::LONG_PERIOD_LOG2)) - 2;
        `CHK(dp, !r)
        if (!r) `CHK(i, x)
        repeat (3) @(negedge clk);
    endtask
    initial begin
        repeat (5) @(negedge clk); rst_n = 1;
        acc(0, 8'h3e, 0, 0);
        be = 1; acc(1, 8'h3e, 16'hffff, 0); be = 3;
        acc(0, 8'h3e, 0, 0);
        w = $random(seed); acc(1, 8'h3e, w, 0);
        acc(0, 8'h3e, 0, w & bdec_pkg::WRITABLE_MASK);
        acc(1, 8'h3c, 16'hffff, 0); acc(0, 8'h3c, 0, 0);
        acc(1, 8'h3e, 16'h0a00, 0); run(1, 0, 1, 0, 1, 1);
        acc(0, 8'h3e, 0, 16'h0e00);
        acc(1, 8'h3e, 16'h0600, 0); acc(0, 8'h3e, 0, 16'h0200);
        run(1, 1, 0, 0, 1, 1);
        acc(1, 8'h3e, 16'h0e00, 0); run(0, 0, 1, 0, 0, 1);
        acc(0, 8'h3e, 0, 16'h0e00);
        run(1, 0, 1, 1, 0, 1);
        acc(1, 8'h3e, 16'h0c00, 0); run(1, 0, 1, 0, 1, 0);
        acc(0, 8'h3e, 0, 16'h0c00);
        `CHK(cnt, 8'd3)
        final_report;
    end
endmodule // tb_top
bind bdec_bridge_control bdec_props u_p (.clk(clk), .rst_n(rst_n), .cfg_rd(cfg_rd),
    .discard_pulse(discard_pulse), .master_repeated(master_repeated),
    .err_msg_valid(err_msg_valid), .err_msg_fatal(err_msg_fatal),
    .aer_fatal_severity(aer_fatal_severity), .aer_discard_mask(aer_discard_mask),
    .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata));
